/* hw/ldsc_serial_control.sv */
// Serial control word, status word, watchdog and PWM outputs of the driver.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Control bits 1-3 address one channel per bank, bit 1 LSB.
// - Bits 4-13 bank A duty, bits 14-23 bank B duty, low bit LSB.
// - Control bit 24 set to 1 disables the watchdog.
// - Bits 25-28 hold the PWM clock divisor code, bit 25 LSB.
// - Bits 29-32 bank A coarse level, bits 33-36 bank B level.
// - Status bits 1-16 report open outputs, zero meaning open.
// - Status bit 17 is one after a watchdog timeout.
// - Status bit 18 is one on overtemperature.
// - Status bits 19-21 return a fixed mask revision, bit 19 LSB.
// - Status bits 22-36 alternate starting with zero at bit 22.
// - No timeout with edges under 25 us apart; timeout after 200 us idle.
// - With strobe low the part is a plain 36-bit shift register.
// - Strobe high stops shifting; fall copies control, next rise loads status.
// - Bit 36 shifts in first and status bit 36 shifts out first.
// - PWM clock is the shift clock divided by divisor code plus one.
module ldsc_serial_control #(
   parameter logic [2:0] MASK_REVISION = 3'h1 // Arbitrary revision value.
) (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic                          serialClockIn,
   input  wire logic                          serialDataIn,
   input  wire logic                          transferStrobe,
   input  wire logic [ldsc_pkg::NUM_OUTPUTS-1:0] openFault,
   input  wire logic                          overTemp,
   output logic                               serialDataOut,
   output logic [ldsc_pkg::NUM_OUTPUTS-1:0]   ledOn,
   output logic [ldsc_pkg::LEVEL_BITS-1:0]    coarseLevelA,
   output logic [ldsc_pkg::LEVEL_BITS-1:0]    coarseLevelB,
   output logic                               watchdogTimedOut
);

   localparam int W  = ldsc_pkg::WORD_BITS;
   localparam int DB = ldsc_pkg::DUTY_BITS;

   // Edge detection of the serial clock, sampled as a synchronous input.
   logic                    sclkPrev_q;
   logic                    sclkRise;
   logic                    sclkFall;

   // Transfer sequencer and shift register.
   ldsc_pkg::ldsc_xfer_state_type state_d;
   ldsc_pkg::ldsc_xfer_state_type state_q;
   logic [W-1:0]            shift_d;
   logic [W-1:0]            shift_q;
   ldsc_pkg::ldsc_control_type ctrlWord;
   ldsc_pkg::ldsc_status_type  statusWord;

   // Control registers.
   logic [DB-1:0]           duty_d [ldsc_pkg::NUM_OUTPUTS];
   logic [DB-1:0]           duty_q [ldsc_pkg::NUM_OUTPUTS];
   logic                    wdDisable_d;
   logic                    wdDisable_q;
   logic [ldsc_pkg::DIV_BITS-1:0]   divisor_d;
   logic [ldsc_pkg::DIV_BITS-1:0]   divisor_q;
   logic [ldsc_pkg::LEVEL_BITS-1:0] levelA_d;
   logic [ldsc_pkg::LEVEL_BITS-1:0] levelA_q;
   logic [ldsc_pkg::LEVEL_BITS-1:0] levelB_d;
   logic [ldsc_pkg::LEVEL_BITS-1:0] levelB_q;
   logic                    configured_d;
   logic                    configured_q;
   logic                    copyControl;

   // Watchdog, thermal and PWM timebase state.
   logic [ldsc_pkg::WD_CNT_BITS-1:0] idle_d;
   logic [ldsc_pkg::WD_CNT_BITS-1:0] idle_q;
   logic                    wdFlag_d;
   logic                    wdFlag_q;
   logic                    thermal_q;
   logic [ldsc_pkg::DIV_BITS-1:0] divCnt_d;
   logic [ldsc_pkg::DIV_BITS-1:0] divCnt_q;
   logic [DB-1:0]           pwmCount_d;
   logic [DB-1:0]           pwmCount_q;
   logic                    forceOff;

   assign sclkRise = serialClockIn && !sclkPrev_q;
   assign sclkFall = !serialClockIn && sclkPrev_q;
   assign ctrlWord = ldsc_pkg::ldsc_control_type'(shift_q);

   // Status word assembled from live fault inputs and flags.
   always_comb begin
      statusWord.okA      = ~openFault[ldsc_pkg::BANK_OUTPUTS-1:0];
      statusWord.okB      = ~openFault[ldsc_pkg::NUM_OUTPUTS-1:ldsc_pkg::BANK_OUTPUTS];
      statusWord.watchdog = wdFlag_q;
      statusWord.thermal  = thermal_q;
      statusWord.maskRev  = MASK_REVISION;
      statusWord.filler   = ldsc_pkg::STATUS_FILLER;
   end

   // Sequencer: shifting while the strobe is low, one copy and one status
   // load while it is high. Shifting toward bit 36 means the first bit in
   // ends in bit 36 and bit 36 is always the one on the serial output.
   always_comb begin
      state_d     = state_q;
      shift_d     = shift_q;
      copyControl = 1'b0;
      if (!transferStrobe) begin
         state_d = ldsc_pkg::XFER_SHIFT;
         if (sclkRise) begin
            shift_d = {shift_q[W-2:0], serialDataIn};
         end
      end else begin
         case (state_q)
            ldsc_pkg::XFER_SHIFT: begin
               // A rising edge in the same cycle as the strobe is not shifted,
               // but a falling edge seen together with the strobe already
               // copies, so a tight controller never loses its word.
               if (sclkFall) begin
                  copyControl = 1'b1;
                  state_d     = ldsc_pkg::XFER_WAIT_RISE;
               end else begin
                  state_d = ldsc_pkg::XFER_WAIT_FALL;
               end
            end
            ldsc_pkg::XFER_WAIT_FALL: begin
               if (sclkFall) begin
                  copyControl = 1'b1;
                  state_d     = ldsc_pkg::XFER_WAIT_RISE;
               end
            end
            ldsc_pkg::XFER_WAIT_RISE: begin
               if (sclkRise) begin
                  shift_d = statusWord;
                  state_d = ldsc_pkg::XFER_HOLD;
               end
            end
            ldsc_pkg::XFER_HOLD: begin
               state_d = ldsc_pkg::XFER_HOLD;
            end
            default: begin
               state_d = ldsc_pkg::XFER_SHIFT;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q    <= ldsc_pkg::XFER_SHIFT;
         shift_q    <= ldsc_pkg::SHIFT_RESET;
         sclkPrev_q <= 1'b0;
      end else begin
         state_q    <= state_d;
         shift_q    <= shift_d;
         sclkPrev_q <= serialClockIn;
      end
   end

   // Control copy: only the addressed channel of each bank takes a duty.
   always_comb begin
      duty_d       = duty_q;
      wdDisable_d  = wdDisable_q;
      divisor_d    = divisor_q;
      levelA_d     = levelA_q;
      levelB_d     = levelB_q;
      configured_d = configured_q;
      if (copyControl) begin
         duty_d[ctrlWord.addr] = ctrlWord.dutyA;
         duty_d[{1'b1, ctrlWord.addr}] = ctrlWord.dutyB;
         wdDisable_d  = ctrlWord.wdDisable;
         divisor_d    = ctrlWord.divisor;
         levelA_d     = ctrlWord.levelA;
         levelB_d     = ctrlWord.levelB;
         configured_d = 1'b1;
      end
   end

   // All outputs stay dark after reset until the first control copy.
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < ldsc_pkg::NUM_OUTPUTS; i++) begin
            duty_q[i] <= ldsc_pkg::DUTY_RESET;
         end
         wdDisable_q  <= 1'b0;
         divisor_q    <= ldsc_pkg::DIV_RESET;
         levelA_q     <= ldsc_pkg::LEVEL_RESET;
         levelB_q     <= ldsc_pkg::LEVEL_RESET;
         configured_q <= 1'b0;
      end else begin
         duty_q       <= duty_d;
         wdDisable_q  <= wdDisable_d;
         divisor_q    <= divisor_d;
         levelA_q     <= levelA_d;
         levelB_q     <= levelB_d;
         configured_q <= configured_d;
      end
   end

   // Watchdog: counts system cycles since the last serial clock rise. The
   // threshold sits at the longest allowed idle time, well clear of the
   // shortest, so a slow but legal controller never trips it.
   always_comb begin
      idle_d   = idle_q;
      wdFlag_d = wdFlag_q;
      if (wdDisable_q) begin
         idle_d   = '0;
         wdFlag_d = 1'b0;
      end else if (sclkRise) begin
         idle_d   = '0;
         wdFlag_d = 1'b0;
      end else if (idle_q != ldsc_pkg::WD_CNT_BITS'(ldsc_pkg::WD_MAX_CYC)) begin
         idle_d = idle_q + 1'b1;
         if (idle_q == ldsc_pkg::WD_CNT_BITS'(ldsc_pkg::WD_MAX_CYC - 1)) begin
            wdFlag_d = 1'b1;
         end
      end
   end

   // PWM timebase: one count every divisor-plus-one serial clock rises.
   always_comb begin
      divCnt_d   = divCnt_q;
      pwmCount_d = pwmCount_q;
      if (sclkRise) begin
         if (divCnt_q >= divisor_q) begin
            divCnt_d   = '0;
            pwmCount_d = pwmCount_q + 1'b1;
         end else begin
            divCnt_d = divCnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         idle_q     <= '0;
         wdFlag_q   <= 1'b0;
         thermal_q  <= 1'b0;
         divCnt_q   <= '0;
         pwmCount_q <= '0;
      end else begin
         idle_q     <= idle_d;
         wdFlag_q   <= wdFlag_d;
         thermal_q  <= overTemp;
         divCnt_q   <= divCnt_d;
         pwmCount_q <= pwmCount_d;
      end
   end

   assign forceOff = wdFlag_q || thermal_q || !configured_q;

   // One comparator channel per output; bank A first, then bank B.
   for (genvar ch = 0; ch < ldsc_pkg::NUM_OUTPUTS; ch++) begin : g_chan
      ldsc_pwm_channel #(
         .DUTY_BITS (DB)
      ) u_chan (
         .clk      (clk),
         .reset    (reset),
         .duty     (duty_q[ch]),
         .count    (pwmCount_q),
         .forceOff (forceOff),
         .ledOn    (ledOn[ch])
      );
   end

   assign serialDataOut    = shift_q[W-1];
   assign coarseLevelA     = levelA_q;
   assign coarseLevelB     = levelB_q;
   assign watchdogTimedOut = wdFlag_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_shift_plain: assert property (
      (!transferStrobe && sclkRise) |=> shift_q == {$past(shift_q[W-2:0]), $past(serialDataIn)})
      else $error("Shift register did not shift on a rising edge.");

   a_hold_no_shift: assert property (
      (transferStrobe && state_q == ldsc_pkg::XFER_WAIT_FALL && !sclkFall) |=> $stable(shift_q))
      else $error("Shift register moved while strobe high.");

   a_copy_fields: assert property (
      (transferStrobe && state_q == ldsc_pkg::XFER_WAIT_FALL && sclkFall)
      |=> divisor_q == $past(shift_q[ldsc_pkg::DIV_LSB+3:ldsc_pkg::DIV_LSB])
          && levelB_q == $past(shift_q[ldsc_pkg::LEVEL_B_LSB+3:ldsc_pkg::LEVEL_B_LSB])
          && wdDisable_q == $past(shift_q[ldsc_pkg::WD_DISABLE_POS]))
      else $error("Control fields not copied on first falling edge.");

   a_copy_duty_a: assert property (
      (transferStrobe && state_q == ldsc_pkg::XFER_WAIT_FALL && sclkFall)
      |=> duty_q[$past(shift_q[2:0])] == $past(shift_q[12:3]))
      else $error("Bank A duty not stored at addressed channel.");

   a_status_load: assert property (
      (transferStrobe && state_q == ldsc_pkg::XFER_WAIT_RISE && sclkRise)
      |=> serialDataOut == 1'b0 && shift_q[W-1:21] == ldsc_pkg::STATUS_FILLER
          && shift_q[20:18] == MASK_REVISION
          && shift_q[7:0] == ~$past(openFault[7:0]))
      else $error("Status word not loaded correctly.");

   a_wd_timeout: assert property (
      (!wdDisable_q && !sclkRise
       && idle_q == ldsc_pkg::WD_CNT_BITS'(ldsc_pkg::WD_MAX_CYC - 1)) |=> wdFlag_q)
      else $error("Watchdog did not time out after idle window.");

   a_wd_quiet: assert property (
      (!wdDisable_q && sclkRise) |=> !wdFlag_q [*8])
      else $error("Watchdog tripped while clock was active.");

   a_pwm_divide: assert property (
      (sclkRise && divCnt_q >= divisor_q) |=> pwmCount_q == $past(pwmCount_q) + 10'h001)
      else $error("PWM count did not advance at divided rate.");

   a_fault_dark: assert property (
      (wdFlag_q || thermal_q) |=> ledOn == '0)
      else $error("Outputs not forced off on fault.");

   c_full_transfer: cover property (
      state_q == ldsc_pkg::XFER_WAIT_RISE && sclkRise && transferStrobe);
   c_wd_timeout: cover property ($rose(wdFlag_q));
   c_pwm_wrap: cover property (pwmCount_q == 10'h3ff && sclkRise && divCnt_q >= divisor_q);

endmodule

`default_nettype wire

/* hw/ldsc_pkg.sv */
// Shared constants and types for the LED driver serial control block.
package ldsc_pkg;

   // Serial word length, output counts, and control and status word field widths.
   localparam int WORD_BITS      = 36;
   localparam int ADDR_BITS      = 3;
   localparam int DUTY_BITS      = 10;
   localparam int DIV_BITS       = 4;
   localparam int LEVEL_BITS     = 4;
   localparam int BANK_OUTPUTS   = 8;
   localparam int NUM_OUTPUTS    = 16;
   localparam int MASK_REV_BITS  = 3;
   localparam int FILLER_BITS    = 15;

   // Field positions inside the shift register, index 0 holds word bit 1.
   localparam int ADDR_LSB       = 0;
   localparam int DUTY_A_LSB     = 3;
   localparam int DUTY_B_LSB     = 13;
   localparam int WD_DISABLE_POS = 23;
   localparam int DIV_LSB        = 24;
   localparam int LEVEL_A_LSB    = 28;
   localparam int LEVEL_B_LSB    = 32;

   // Status filler: word bit 22 reads 0, then the bits alternate.
   localparam logic [FILLER_BITS-1:0] STATUS_FILLER = 15'h2aaa;

   // Clock period and watchdog window, each in its own unit.
   localparam int CLK_PERIOD_NS  = 100;
   localparam int WD_MIN_US      = 25;
   localparam int WD_MAX_US      = 200;
   // Quiet time is a least time (round up), timeout a longest time (round down).
   localparam int WD_MIN_CYC = (WD_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WD_MAX_CYC = (WD_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int WD_CNT_BITS    = 11;

   // Values after reset: all duties zero, watchdog active, divide by one.
   localparam logic [DUTY_BITS-1:0]  DUTY_RESET  = 10'h000;
   localparam logic [DIV_BITS-1:0]   DIV_RESET   = 4'h0;
   localparam logic [LEVEL_BITS-1:0] LEVEL_RESET = 4'h0;
   localparam logic [WORD_BITS-1:0]  SHIFT_RESET = 36'h000000000;

   // Control word as shifted in, most significant field first.
   typedef struct packed {
      logic [LEVEL_BITS-1:0] levelB;
      logic [LEVEL_BITS-1:0] levelA;
      logic [DIV_BITS-1:0]   divisor;
      logic                  wdDisable;
      logic [DUTY_BITS-1:0]  dutyB;
      logic [DUTY_BITS-1:0]  dutyA;
      logic [ADDR_BITS-1:0]  addr;
   } ldsc_control_type;

   // Status word as loaded for shifting out.
   typedef struct packed {
      logic [FILLER_BITS-1:0]   filler;
      logic [MASK_REV_BITS-1:0] maskRev;
      logic                     thermal;
      logic                     watchdog;
      logic [BANK_OUTPUTS-1:0]  okB;
      logic [BANK_OUTPUTS-1:0]  okA;
   } ldsc_status_type;

   // Transfer sequencer states.
   typedef enum logic [1:0] {
      XFER_SHIFT     = 2'b00,
      XFER_WAIT_FALL = 2'b01,
      XFER_WAIT_RISE = 2'b10,
      XFER_HOLD      = 2'b11
   } ldsc_xfer_state_type;

endpackage

/* hw/ldsc_pwm_channel.sv */
// One PWM output channel comparing the shared count with its duty value.
`timescale 1ns/1ps
`default_nettype none

module ldsc_pwm_channel #(
   parameter int DUTY_BITS = 10
) (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic [DUTY_BITS-1:0] duty,
   input  wire logic [DUTY_BITS-1:0] count,
   input  wire logic                 forceOff,
   output logic                      ledOn
);

   logic ledOn_d;
   logic ledOn_q;

   // The output is off past the duty value and whenever a fault forces it.
   always_comb begin
      ledOn_d = !forceOff && !(count > duty);
   end

   // Registered so the pin never glitches while the count ripples.
   always_ff @(posedge clk) begin
      if (reset) begin
         ledOn_q <= 1'b0;
      end else begin
         ledOn_q <= ledOn_d;
      end
   end

   assign ledOn = ledOn_q;

   a_channel_off_past: assert property (@(posedge clk) disable iff (reset)
      (count > duty) |=> !ledOn)
      else $error("Channel on while count exceeds duty.");

   a_channel_forced: assert property (@(posedge clk) disable iff (reset)
      forceOff |=> !ledOn)
      else $error("Channel on while forced off.");

endmodule

`default_nettype wire

/* tb/ldsc_ctrl_model.sv */
// Behavioural display controller that shifts words into the driver and reads its status back.
`timescale 1ns/1ps
`default_nettype none

module ldsc_ctrl_model (
   input  wire logic  clk,
   input  wire logic  serialDataOut,
   output logic       serialClockIn,
   output logic       serialDataIn,
   output logic       transferStrobe,
   output logic [35:0] lastStatus
);
   // The shift clock rests low at reset release so no false rise is seen.
   initial begin
      serialClockIn  = 1'b0;
      serialDataIn   = 1'b0;
      transferStrobe = 1'b0;
      lastStatus     = 36'h000000000;
   end

   // Each clock level stands two system cycles, so the driver sees every edge.
   task automatic edges(input logic lvl);
      serialClockIn = lvl;
      repeat (2) @(negedge clk);
   endtask

   // Shift n bits, the last 36 being the word with its bit 36 first; earlier bits are filler.
   task automatic shift(input logic [35:0] word, input int n);
      for (int k = n - 1; k >= 0; k--) begin
         serialDataIn = (k < 36) ? word[k] : 1'($urandom);
         edges(1'b0);
         lastStatus = {lastStatus[34:0], serialDataOut};
         edges(1'b1);
      end
      // A released data line shows the inverse, never a stale copy.
      serialDataIn = ~serialDataIn;
   endtask

   // Strobe high, then a fall copies the control word and the next rise loads status.
   task automatic latch();
      transferStrobe = 1'b1;
      edges(1'b1);
      edges(1'b0);
      edges(1'b1);
      edges(1'b0);
      transferStrobe = 1'b0;
      repeat (2) @(negedge clk);
   endtask
endmodule

`default_nettype wire

/* tb/led_driver_serial_control_tb.sv */
// Self-checking testbench for the LED driver serial control block.
`timescale 1ns/1ps
`default_nettype none

module led_driver_serial_control_tb;
   localparam logic [2:0] REV = 3'h5; // Arbitrary revision value.

   logic        clk = 1'b0;
   logic        reset;
   logic [15:0] openFault;
   logic        overTemp;
   logic        sclk, sdi, strobe, sdo, wdFlag;
   logic [15:0] ledOn;
   logic [3:0]  levelA, levelB;
   logic [35:0] lastStatus, measured, w;
   logic [9:0]  dutyMem [16];
   int          cnt [16];
   int          qKind [$];
   logic [35:0] qExp [$];
   int          numErrors = 0;
   int          nTests = 0;
   int          k, i;
   logic [35:0] e, o;
   string       names [6] = '{"status", "ledOn", "levels", "watchdog", "measure", "serialOut"};
   event        chk;

   // 10 MHz system clock.
   always #50 clk = ~clk;

   ldsc_serial_control #(.MASK_REVISION(REV)) DUT (
      .clk(clk), .reset(reset), .serialClockIn(sclk), .serialDataIn(sdi),
      .transferStrobe(strobe), .openFault(openFault), .overTemp(overTemp),
      .serialDataOut(sdo), .ledOn(ledOn), .coarseLevelA(levelA),
      .coarseLevelB(levelB), .watchdogTimedOut(wdFlag));

   ldsc_ctrl_model ctrl (
      .clk(clk), .serialDataOut(sdo), .serialClockIn(sclk), .serialDataIn(sdi),
      .transferStrobe(strobe), .lastStatus(lastStatus));

   // Expected status word built field by field, independent of the package layout.
   function automatic logic [35:0] stat(logic [15:0] of, logic th, logic wd);
      return {15'h2aaa, REV, th, wd, ~of};
   endfunction

   // Control word from its fields.
   function automatic logic [35:0] mk(logic [2:0] a, logic [9:0] da, logic [9:0] db,
                                      logic wd, logic [3:0] dv);
      return {4'h9, 4'h6, dv, wd, db, da, a};
   endfunction

   // Note an expectation; the monitor compares it with what the outputs show now.
   task automatic check(input int kind, input logic [35:0] ex);
      qKind.push_back(kind);
      qExp.push_back(ex);
      -> chk;
      #1;
   endtask

   // Shift and latch one word, remembering the duties it programs.
   task automatic xfer(input logic [35:0] cw);
      ctrl.shift(cw, 36);
      ctrl.latch();
      dutyMem[cw[2:0]] = cw[12:3];
      dutyMem[8 + cw[2:0]] = cw[22:13];
   endtask

   task automatic summarize();
      if (numErrors == 0 && nTests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Monitor: takes the oldest note and compares it with the matching output.
   always @(chk) begin
      while (qKind.size() > 0) begin
         k = qKind.pop_front();
         e = qExp.pop_front();
         case (k)
            0: o = lastStatus;
            1: o = {20'h00000, ledOn};
            2: o = {28'h0000000, levelB, levelA};
            3: o = {35'h000000000, wdFlag};
            4: o = measured;
            default: o = {35'h000000000, sdo};
         endcase
         nTests++;
         if (o !== e) begin
            $display("mismatch %s expected %h seen %h", names[k], e, o);
            numErrors++;
         end
      end
   end

   initial begin
      void'($urandom(71));
      reset = 1'b1;
      overTemp = 1'b0;
      openFault = 16'h0000;
      foreach (dutyMem[c]) dutyMem[c] = 10'h000;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      check(1, 36'h0); // RESET
      check(2, 36'h0); // RESET
      check(5, 36'h0); // RESET

      // Random words; each shift returns the status loaded at the previous latch.
      for (int n = 0; n < 6; n++) begin
         w = {4'($urandom), 32'($urandom)};
         w[23] = 1'b0;
         ctrl.shift(w, 36);
         if (n > 0) check(0, stat(openFault, 1'b0, 1'b0));
         openFault = 16'($urandom);
         ctrl.latch();
         dutyMem[w[2:0]] = w[12:3];
         dutyMem[8 + w[2:0]] = w[22:13];
         check(2, {28'h0, w[35:32], w[31:28]});
         check(5, 36'h0);
      end

      // Duty per channel seen as on-time over one full PWM period, for two divisors.
      foreach (cnt[c]) cnt[c] = 0;
      for (int dv = 0; dv < 4; dv += 3) begin
         xfer(mk(3'($urandom), 10'($urandom), 10'($urandom), 1'b0, 4'(dv)));
         fork
            ctrl.shift(36'h0, 1100 * (dv + 1));
            begin
               repeat (100) @(negedge clk);
               foreach (cnt[c]) cnt[c] = 0;
               repeat (4096 * (dv + 1)) begin
                  @(negedge clk);
                  foreach (cnt[c]) cnt[c] += int'(ledOn[c]);
               end
            end
         join
         foreach (cnt[c]) begin
            measured = 36'(cnt[c]);
            check(4, 36'(4 * (dv + 1) * (dutyMem[c] + 1)));
         end
      end

      // Overtemperature forces a full-duty channel off and shows in status.
      xfer(mk(3'h2, 10'h3ff, 10'h3ff, 1'b0, 4'h0));
      repeat (4) @(negedge clk);
      measured = {35'h0, ledOn[2]};
      check(4, 36'h1);
      overTemp = 1'b1;
      repeat (3) @(negedge clk);
      check(1, 36'h0);
      xfer(mk(3'h2, 10'h3ff, 10'h3ff, 1'b0, 4'h0));
      ctrl.shift(36'h0, 36);
      check(0, stat(openFault, 1'b1, 1'b0));
      overTemp = 1'b0;
      xfer(mk(3'h2, 10'h3ff, 10'h3ff, 1'b0, 4'h0));

      // Shift clock stands still: no timeout early, a timeout by the longest time.
      for (i = 0; i < 2010 && wdFlag !== 1'b1; i++) begin
         @(negedge clk);
         if (i == 250) check(3, 36'h0);
      end
      measured = {35'h0, (i > 250 && i <= 2005)};
      check(4, 36'h1);
      check(3, 36'h1);
      // The outputs go dark one clock after the flag register, so let it pass.
      repeat (2) @(negedge clk);
      check(1, 36'h0);
      if (wdFlag === 1'b1) begin
         ctrl.shift(36'h0, 36);
         check(3, 36'h0);

         // With supervision disabled a long idle raises no timeout.
         xfer(mk(3'h0, 10'h100, 10'h100, 1'b1, 4'h0));
         repeat (2100) @(negedge clk);
         check(3, 36'h0);
      end
      summarize();
   end
endmodule

`default_nettype wire
